// *** core/event_status_and_state_commands.sv ***
// Event latch, enable mask, status queries and state save/recall.
// Assumes a parser on clk_i delivers decoded commands and error pulses,
// and that busy_i stays high while the switch mechanics move.
//
// Operation
// - Event latch bits 7,6,5,4,2,0 hold power-on, request, errors, complete.
// - Eight-bit enable mask, same bit layout, one enables the event.
// - Latch query answers the latch value as decimal 0 to 245.
// - Latch query clears the latch after capturing the answer.
// - Identification query answers maker, model and revision text.
// - Queries after the identification query in one message are ignored.
// - Operation complete command sets its bit after all motion ends.
// - Operation complete query answers "1" newline after motion ends.
// - Recall restores slot 0 to 9, or power-on state if never saved.
// - Save copies current state to slot 0 to 9 and marks it stored.
// - Reset command puts every port to off or channel 1.
// - Latch bits reach the summary flag only where the mask is one.
// - Mask clears at power-on, survives reset and clear-status commands.
`timescale 1ns/1ns
`default_nettype none
`include "evt_map.svh"

module event_status_and_state_commands #(
	parameter int SLOTS = `EVT_SLOTS,
	parameter int W     = `EVT_STATE_W
) (
	input  wire logic                clk_i,
	input  wire logic                resetn_i,
	input  wire logic                cmd_valid_i,
	input  wire evt_pkg::command_type cmd_i,
	output logic                     cmd_ready_o,
	input  wire evt_pkg::events_type  events_i,
	input  wire logic                busy_i,
	output logic                     resp_valid_o,
	output logic [7:0]               resp_data_o,
	output logic                     resp_last_o,
	input  wire logic                resp_ready_i,
	output logic [W-1:0]             switch_pos_o,
	output logic                     move_o,
	output logic [7:0]               event_latch_o,
	output logic [7:0]               event_enable_mask_o,
	output logic                     event_summary_flag_o
);
	import evt_pkg::*;

	function automatic nr1_type to_nr1(input logic [7:0] v);
		nr1_type    r;
		logic [7:0] h;
		logic [7:0] t;
		logic [7:0] o;
		h = (v / 8'd100) + `EVT_ASCII_ZERO;
		t = ((v / 8'd10) % 8'd10) + `EVT_ASCII_ZERO;
		o = (v % 8'd10) + `EVT_ASCII_ZERO;
		r = '0;
		if (v >= 8'd100)
			r = '{len: 3'd4, ch: {`EVT_ASCII_NL, o, t, h}};
		else if (v >= 8'd10)
			r = '{len: 3'd3, ch: {8'h00, `EVT_ASCII_NL, o, t}};
		else
			r = '{len: 3'd2, ch: {8'h00, 8'h00, `EVT_ASCII_NL, o}};
		return r;
	endfunction

	function automatic logic is_query(input opcode_type op);
		return (op == op_query_mask) || (op == op_query_latch) ||
			(op == op_query_id) || (op == op_query_op_complete);
	endfunction

	logic [7:0]    event_latch, event_enable_mask, set_vec;
	logic [7:0]    id_char, cur_char;
	logic          pon_done, idn_seen, opc_pend, busy_any, take;
	logic          drop_query, read_clear, cls, slot_ok, exe_int;
	logic          rd_stored, id_last, reply_id, sent_last, cur_last;
	logic [W-1:0]  rd_data;
	logic [4:0]    reply_idx;
	seq_state_type state;
	nr1_type       reply_buf;

	assign take       = cmd_valid_i && cmd_ready_o;
	assign drop_query = idn_seen && is_query(cmd_i.op);
	assign read_clear = take && cmd_i.op == op_query_latch && !drop_query;
	assign cls        = take && cmd_i.op == op_clear_status;
	// The move pulse covers the cycle before the mechanics raise busy_i
	assign busy_any   = busy_i || move_o;
	assign slot_ok    = (int'(cmd_i.value) < SLOTS);
	assign exe_int    = take && !slot_ok &&
		(cmd_i.op == op_recall || cmd_i.op == op_save);

	state_store #(
		.SLOTS(SLOTS),
		.W    (W)
	) u_store (
		.clk_i      (clk_i),
		.resetn_i   (resetn_i),
		.wr_i       (take && slot_ok && cmd_i.op == op_save),
		.idx_i      (cmd_i.value[3:0]),
		.wr_data_i  (switch_pos_o),
		.rd_data_o  (rd_data),
		.rd_stored_o(rd_stored)
	);

	id_rom #(
		.LEN(`EVT_ID_LEN)
	) u_id (
		.idx_i (reply_idx),
		.char_o(id_char),
		.last_o(id_last)
	);

	always_comb
	begin
		set_vec = 8'h00;
		set_vec[`EVT_PON_BIT] = !pon_done;
		set_vec[`EVT_URQ_BIT] = events_i.user_request_event;
		set_vec[`EVT_CME_BIT] = events_i.command_error_event;
		set_vec[`EVT_EXE_BIT] = events_i.execution_error_event || exe_int;
		set_vec[`EVT_QYE_BIT] = events_i.query_error_event;
		set_vec[`EVT_OPC_BIT] = opc_pend && !busy_any;
	end

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			pon_done <= 1'b0;
		else
			pon_done <= 1'b1;
	end

	// A set in the clearing cycle survives the clear
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			event_latch <= `EVT_LATCH_RST;
		else if (read_clear || cls)
			event_latch <= set_vec & `EVT_USED_BITS;
		else
			event_latch <= (event_latch | set_vec) & `EVT_USED_BITS;
	end

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			event_enable_mask <= `EVT_MASK_RST;
		else if (take && cmd_i.op == op_set_mask)
			event_enable_mask <= cmd_i.value & `EVT_USED_BITS;
	end

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			event_summary_flag_o <= 1'b0;
		else
			event_summary_flag_o <= |(event_latch & event_enable_mask);
	end

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			opc_pend <= 1'b0;
		else if (take && cmd_i.op == op_op_complete)
			opc_pend <= 1'b1;
		else if (cls || !busy_any)
			opc_pend <= 1'b0;
	end

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			idn_seen <= 1'b0;
		else if (take && cmd_i.end_of_msg)
			idn_seen <= 1'b0;
		else if (take && cmd_i.op == op_query_id && !drop_query)
			idn_seen <= 1'b1;
	end

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			switch_pos_o <= W'(`EVT_POWER_ON_POS);
			move_o <= 1'b0;
		end
		else
		begin
			move_o <= 1'b0;
			if (take)
			begin
				case (cmd_i.op)
					op_route:
					begin
						switch_pos_o <= cmd_i.pos;
						move_o <= 1'b1;
					end
					op_reset:
					begin
						switch_pos_o <= W'(`EVT_POWER_ON_POS);
						move_o <= 1'b1;
					end
					op_recall:
					begin
						if (slot_ok)
							switch_pos_o <= rd_data;
						move_o <= slot_ok;
					end
					default:
						move_o <= 1'b0;
				endcase
			end
		end
	end

	assign cur_char = reply_id ? id_char : reply_buf.ch[reply_idx[1:0]];
	assign cur_last = reply_id ? id_last
		: (reply_idx[2:0] == reply_buf.len - 3'd1);

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			state <= st_idle;
			cmd_ready_o <= 1'b1;
			reply_buf <= '0;
			reply_id <= 1'b0;
			reply_idx <= 5'h00;
			sent_last <= 1'b0;
			resp_valid_o <= 1'b0;
			resp_data_o <= 8'h00;
			resp_last_o <= 1'b0;
		end
		else
		begin
			case (state)
				st_idle:
				begin
					reply_idx <= 5'h00;
					sent_last <= 1'b0;
					reply_id <= (cmd_i.op == op_query_id);
					if (take && !drop_query && is_query(cmd_i.op))
					begin
						// Latch answer is the value from before its clear
						reply_buf <= to_nr1(cmd_i.op == op_query_mask
							? event_enable_mask : event_latch);
						state <= (cmd_i.op == op_query_op_complete)
							? st_wait_opc : st_reply;
						cmd_ready_o <= 1'b0;
					end
				end
				st_wait_opc:
				begin
					if (!busy_any)
					begin
						reply_buf <= '{len: 3'd2, ch: {8'h00, 8'h00,
							`EVT_ASCII_NL, `EVT_ASCII_ONE}};
						state <= st_reply;
					end
				end
				st_reply:
				begin
					if (!resp_valid_o || resp_ready_i)
					begin
						if (sent_last)
						begin
							resp_valid_o <= 1'b0;
							resp_last_o <= 1'b0;
							state <= st_idle;
							cmd_ready_o <= 1'b1;
						end
						else
						begin
							resp_valid_o <= 1'b1;
							resp_data_o <= cur_char;
							resp_last_o <= cur_last;
							sent_last <= cur_last;
							reply_idx <= reply_idx + 5'd1;
						end
					end
				end
				default:
				begin
					state <= st_idle;
					cmd_ready_o <= 1'b1;
				end
			endcase
		end
	end

	assign event_latch_o = event_latch;
	assign event_enable_mask_o = event_enable_mask;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!resetn_i);

	a_latch_read_clear: assert property (
		(read_clear && set_vec == 8'h00) |=> event_latch == 8'h00)
		else $error("latch not cleared by its query");
	a_latch_read_value: assert property (
		read_clear |=> reply_buf == to_nr1($past(event_latch)))
		else $error("latch query answer differs from latch");
	a_latch_bits_hold: assert property (
		!(read_clear || cls) |=>
		(event_latch & $past(event_latch)) == $past(event_latch))
		else $error("latch bit dropped without clear");
	a_spare_bits_zero: assert property (
		event_latch[`EVT_SPARE_HI_BIT] == 1'b0 &&
		event_latch[`EVT_SPARE_LO_BIT] == 1'b0)
		else $error("unused latch bit set");
	a_summary_masked: assert property (
		##1 event_summary_flag_o ==
		$past(|(event_latch & event_enable_mask)))
		else $error("summary flag ignores mask");
	a_mask_kept: assert property (
		(take && (cmd_i.op == op_clear_status || cmd_i.op == op_reset))
		|=> $stable(event_enable_mask))
		else $error("mask changed by reset or clear");
	a_opc_after_motion: assert property (
		$rose(event_latch[`EVT_OPC_BIT]) |-> !$past(busy_any))
		else $error("complete bit set while moving");
	a_opc_query_waits: assert property (
		(state == st_wait_opc && busy_any) |=> state == st_wait_opc)
		else $error("complete answer before motion ended");
	a_recall_unstored: assert property (
		(take && cmd_i.op == op_recall && slot_ok && !rd_stored)
		|=> switch_pos_o == W'(`EVT_POWER_ON_POS))
		else $error("unstored recall not power-on state");
	a_reset_positions: assert property (
		(take && cmd_i.op == op_reset)
		|=> switch_pos_o == W'(`EVT_POWER_ON_POS) && move_o)
		else $error("reset did not restore positions");
	a_query_dropped: assert property (
		(take && drop_query) |=> state == st_idle && cmd_ready_o)
		else $error("query after identification answered");

	c_latch_read: cover property (read_clear && event_latch != 8'h00);
	c_opc_wait: cover property (state == st_wait_opc ##1 state == st_reply);
	c_id_reply: cover property (resp_valid_o && resp_last_o && reply_id);
endmodule // event_status_and_state_commands

`default_nettype wire

// *** core/evt_map.svh ***
// Constants for the event status and state command block.
// Assumes inclusion by bare name from the package and the modules.
`ifndef EVT_MAP_SVH
`define EVT_MAP_SVH

`define EVT_PON_BIT      7
`define EVT_URQ_BIT      6
`define EVT_CME_BIT      5
`define EVT_EXE_BIT      4
`define EVT_SPARE_HI_BIT 3
`define EVT_QYE_BIT      2
`define EVT_SPARE_LO_BIT 1
`define EVT_OPC_BIT      0

`define EVT_LATCH_RST    8'h00
`define EVT_MASK_RST     8'h00
`define EVT_USED_BITS    8'hf5

`define EVT_SLOTS        10
`define EVT_STATE_W      16
`define EVT_POWER_ON_POS 16'h0000

`define EVT_ID_LEN       30
`define EVT_ASCII_NL     8'h0a
`define EVT_ASCII_ZERO   8'h30
`define EVT_ASCII_ONE    8'h31

`endif

// *** core/evt_pkg.sv ***
// Types shared by the event status and state command block.
// Assumes evt_map.svh is on the include path.
`include "evt_map.svh"

package evt_pkg;

	typedef enum logic [3:0] {
		op_none,
		op_clear_status,
		op_set_mask,
		op_query_mask,
		op_query_latch,
		op_query_id,
		op_op_complete,
		op_query_op_complete,
		op_recall,
		op_save,
		op_reset,
		op_route
	} opcode_type;

	typedef struct packed {
		opcode_type              op;
		logic                    end_of_msg;
		logic [7:0]              value;
		logic [`EVT_STATE_W-1:0] pos;
	} command_type;

	typedef struct packed {
		logic user_request_event;
		logic command_error_event;
		logic execution_error_event;
		logic query_error_event;
	} events_type;

	typedef struct packed {
		logic [2:0]      len;
		logic [3:0][7:0] ch;
	} nr1_type;

	typedef enum {st_idle, st_reply, st_wait_opc} seq_state_type;

endpackage

// *** core/id_rom.sv ***
// Identification text, one character per index, newline last.
// Assumes the caller walks idx_i from zero and stops after last_o.
`timescale 1ns/1ns
`default_nettype none
`include "evt_map.svh"

module id_rom #(
	parameter int LEN = `EVT_ID_LEN
) (
	input  wire logic [4:0] idx_i,
	output logic      [7:0] char_o,
	output logic            last_o
);
	// Maker, model and revision text; the value is arbitrary
	localparam logic [8*(LEN-1)-1:0] TEXT = "VENDOR SWITCH, 0, VERSION 1.0";

	int pos;

	always_comb
	begin
		pos = LEN - 2 - int'(idx_i);
		if (int'(idx_i) == LEN - 1)
			char_o = `EVT_ASCII_NL;
		else if (pos >= 0)
			char_o = TEXT[8*pos +: 8];
		else
			char_o = 8'h00;
		last_o = (int'(idx_i) == LEN - 1);
	end
endmodule // id_rom

`default_nettype wire

// *** core/state_store.sv ***
// Instrument state slots with a stored flag per slot.
// Assumes one write at a time; reads are combinational.
`timescale 1ns/1ns
`default_nettype none
`include "evt_map.svh"

module state_store #(
	parameter int SLOTS = `EVT_SLOTS,
	parameter int W     = `EVT_STATE_W
) (
	input  wire logic         clk_i,
	input  wire logic         resetn_i,
	input  wire logic         wr_i,
	input  wire logic [3:0]   idx_i,
	input  wire logic [W-1:0] wr_data_i,
	output logic      [W-1:0] rd_data_o,
	output logic              rd_stored_o
);
	logic [W-1:0]     slot_mem [SLOTS];
	logic [SLOTS-1:0] stored;
	logic             in_range;

	assign in_range = (int'(idx_i) < SLOTS);

	always_ff @(posedge clk_i)
	begin
		if (wr_i && in_range)
			slot_mem[idx_i] <= wr_data_i;
	end

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			stored <= '0;
		else if (wr_i && in_range)
			stored[idx_i] <= 1'b1;
	end

	assign rd_stored_o = in_range && stored[idx_i];
	// Unwritten slots give back the power-on positions
	assign rd_data_o = rd_stored_o ? slot_mem[idx_i]
		: W'(`EVT_POWER_ON_POS);
endmodule // state_store

`default_nettype wire

// *** sim/event_status_and_state_commands_bench.sv ***
// Bench for the event status and state command block.
// Assumes host_model drives the command port and collects replies.
`timescale 1ns/1ns
`default_nettype none

module event_status_and_state_commands_bench;
	import evt_pkg::*;
	logic        clk_i = 1'b0;
	logic        resetn_i = 1'b0;
	logic        busy = 1'b0;
	events_type  events = '0;
	command_type cmd;
	logic        cmd_valid, cmd_ready, resp_valid, resp_ready;
	logic        resp_last, move, summary;
	logic [7:0]  resp_data, event_latch, enable_mask, exp;
	logic [15:0] switch_pos;
	logic [7:0]  wt[4] = '{8'h40, 8'h20, 8'h10, 8'h04};
	int          n_errors = 0;
	int          n_checks = 0;
	int          n_taken = 0;
	int          last_at = 0;
	int          n_moves = 0;

	always #4 clk_i = !clk_i;

	event_status_and_state_commands dut_u (
		.clk_i(clk_i), .resetn_i(resetn_i), .cmd_valid_i(cmd_valid),
		.cmd_i(cmd), .cmd_ready_o(cmd_ready), .events_i(events),
		.busy_i(busy), .resp_valid_o(resp_valid), .resp_data_o(resp_data),
		.resp_last_o(resp_last), .resp_ready_i(resp_ready),
		.switch_pos_o(switch_pos), .move_o(move),
		.event_latch_o(event_latch), .event_enable_mask_o(enable_mask),
		.event_summary_flag_o(summary));

	host_model host_u (
		.clk_i(clk_i), .cmd_valid_o(cmd_valid), .cmd_o(cmd),
		.cmd_ready_i(cmd_ready), .resp_valid_i(resp_valid),
		.resp_data_i(resp_data), .resp_ready_o(resp_ready));

	// Where the last flag came in the reply, and how many move pulses
	always @(posedge clk_i)
	begin
		if (resp_valid && resp_ready)
		begin
			n_taken <= n_taken + 1;
			if (resp_last)
				last_at <= n_taken + 1;
		end
		if (move)
			n_moves <= n_moves + 1;
	end

	task automatic chk(input string what, input logic [15:0] seen, exp_v);
		n_checks++;
		if (seen !== exp_v)
		begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp_v, seen);
		end
	endtask

	task automatic expect_reply(input string s);
		chk("reply length", 16'(host_u.reply.size()), 16'(s.len()));
		for (int i = 0; i < s.len(); i++)
			chk("reply byte", {8'h00, host_u.reply[i]}, {8'h00, s[i]});
		chk("last flag", 16'(last_at), 16'(s.len()));
		n_taken = 0;
		last_at = 0;
	endtask

	// Two edges let both the effect and the lagging summary land
	task automatic settle;
		repeat (2) @(posedge clk_i);
		#1;
	endtask

	task automatic cmd_do(input opcode_type op, input logic [7:0] v,
		input logic [15:0] p);
		host_u.send(op, v, 1'b1, p);
		settle;
	endtask

	task automatic pulse(input logic [3:0] e);
		@(posedge clk_i);
		events <= events_type'(e);
		@(posedge clk_i);
		events <= '0;
	endtask

	task automatic done(input string name);
		$display("test %s done", name);
	endtask

	task automatic close_out;
		$display("checks %0d mismatches %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	initial
	begin
		repeat (20000) @(posedge clk_i);
		n_errors++;
		close_out;
	end

	initial
	begin
		repeat (8) @(posedge clk_i);
		resetn_i <= 1'b1;
		@(posedge clk_i);
		#1;
		chk("latch", 16'(event_latch), 16'h0080);
		chk("mask", 16'(enable_mask), 16'h0000);
		chk("position", switch_pos, 16'h0000);
		done("reset");
		cmd_do(op_set_mask, 8'h80, 16'h0000);
		chk("summary", 16'(summary), 16'h0001);
		cmd_do(op_set_mask, 8'h7f, 16'h0000);
		chk("summary", 16'(summary), 16'h0000);
		cmd_do(op_set_mask, 8'hff, 16'h0000);
		chk("mask", 16'(enable_mask), 16'h00f5);
		host_u.query(op_query_mask, 1'b1);
		expect_reply("245\n");
		done("mask");
		exp = 8'h80;
		foreach (wt[i])
		begin
			pulse(4'(4'h8 >> i));
			exp |= wt[i];
			settle;
			chk("latch", 16'(event_latch), 16'(exp));
		end
		repeat (10) @(posedge clk_i);
		chk("latch held", 16'(event_latch), 16'h00f4);
		host_u.slow = 1'b1;
		host_u.query(op_query_latch, 1'b1);
		expect_reply("244\n");
		host_u.slow = 1'b0;
		settle;
		chk("latch", 16'(event_latch), 16'h0000);
		host_u.query(op_query_latch, 1'b1);
		expect_reply("0\n");
		done("latch");
		pulse(4'h8);
		cmd_do(op_clear_status, 8'h00, 16'h0000);
		chk("latch", 16'(event_latch), 16'h0000);
		chk("mask", 16'(enable_mask), 16'h00f5);
		done("clear");
		@(posedge clk_i);
		busy <= 1'b1;
		host_u.send(op_route, 8'h00, 1'b1, 16'h1234);
		host_u.send(op_op_complete, 8'h00, 1'b1, 16'h0000);
		repeat (6) @(posedge clk_i);
		busy <= 1'b0;
		#1;
		chk("complete early", 16'(event_latch), 16'h0000);
		repeat (4) @(posedge clk_i);
		#1;
		chk("complete", 16'(event_latch), 16'h0001);
		@(posedge clk_i);
		busy <= 1'b1;
		fork
			host_u.query(op_query_op_complete, 1'b1);
			begin
				repeat (15) @(posedge clk_i);
				chk("early reply", 16'(host_u.reply.size()), 16'h0000);
				busy <= 1'b0;
			end
		join
		expect_reply("1\n");
		done("complete");
		cmd_do(op_save, 8'h09, 16'h0000);
		cmd_do(op_reset, 8'h00, 16'h0000);
		chk("position", switch_pos, 16'h0000);
		chk("mask", 16'(enable_mask), 16'h00f5);
		cmd_do(op_recall, 8'h09, 16'h0000);
		chk("position", switch_pos, 16'h1234);
		cmd_do(op_save, 8'h13, 16'h0000);
		chk("bad slot", 16'(event_latch), 16'h0011);
		cmd_do(op_recall, 8'h03, 16'h0000);
		chk("position", switch_pos, 16'h0000);
		cmd_do(op_save, 8'h0a, 16'h0000);
		chk("bad slot", 16'(event_latch), 16'h0011);
		chk("move pulses", 16'(n_moves), 16'h0004);
		done("state");
		host_u.query(op_query_id, 1'b0);
		expect_reply("VENDOR SWITCH, 0, VERSION 1.0\n");
		host_u.query(op_query_latch, 1'b1);
		chk("ignored reply", 16'(host_u.reply.size()), 16'h0000);
		host_u.query(op_query_latch, 1'b1);
		expect_reply("17\n");
		done("ident");
		close_out;
	end
endmodule // event_status_and_state_commands_bench

`default_nettype wire

// *** sim/host_model.sv ***
// Host controller model: sends commands and collects answer bytes.
// Assumes the block takes a command on valid and ready at a rising edge.
`timescale 1ns/1ns
`default_nettype none

module host_model (
	input  wire logic            clk_i,
	output logic                 cmd_valid_o,
	output evt_pkg::command_type cmd_o,
	input  wire logic            cmd_ready_i,
	input  wire logic            resp_valid_i,
	input  wire logic [7:0]      resp_data_i,
	output logic                 resp_ready_o
);
	import evt_pkg::*;
	logic       slow = 1'b0;
	logic [7:0] reply[$];

	initial
	begin
		cmd_valid_o = 1'b0;
		cmd_o = '0;
		resp_ready_o = 1'b1;
	end

	// Slow mode drops ready every other cycle to prove bytes are held
	always @(posedge clk_i)
	begin
		if (resp_valid_i && resp_ready_o)
			reply.push_back(resp_data_i);
		resp_ready_o <= slow ? !resp_ready_o : 1'b1;
	end

	// Request stays unchanged until the edge that takes it
	task automatic send(input opcode_type op, input logic [7:0] v,
		input logic eom, input logic [15:0] p);
		@(posedge clk_i);
		cmd_valid_o <= 1'b1;
		cmd_o <= '{op, eom, v, p};
		// A hang is left to the bench watchdog, which fails the run
		do
			@(posedge clk_i);
		while (!cmd_ready_i);
		cmd_valid_o <= 1'b0;
	endtask

	// A dropped query never lowers ready, so the wait ends at once
	task automatic query(input opcode_type op, input logic eom);
		reply.delete();
		send(op, 8'h00, eom, 16'h0000);
		repeat (3) @(posedge clk_i);
		while (!cmd_ready_i)
			@(posedge clk_i);
	endtask
endmodule // host_model

`default_nettype wire
